// ===== hdl/cpu_reset_sleep_thermal_ctrl.sv
`timescale 1ns/100ps
module cpu_reset_sleep_thermal_ctrl #(
	parameter int unsigned STRAP_W = cpu_ctrl_pkg::STRAP_W
) (
	input  wire logic               mclk_in,
	input  wire logic               rst_in,
	cpu_ctrl_if.device              link,
	input  wire logic               temp_max_in,
	input  wire logic               tcc_enable_in,
	input  wire logic               snoop_req_in,
	input  wire logic               irq_req_in,
	input  wire logic               bus_out_req_in,
	output logic                    thermal_control_circuit_out,
	output logic                    core_clk_en_out,
	output logic                    bus_clk_en_out,
	output logic                    apic_clk_en_out,
	output logic                    pll_on_out,
	output logic                    executing_out,
	output logic                    cache_invalidate_out,
	output logic                    bus_out_en_out,
	output logic                    snoop_accept_out,
	output logic                    irq_accept_out,
	output logic [STRAP_W-1:0]      strap_out,
	output logic [1:0]              power_state_out
);

	// Power state and the registered side outputs that follow it
	cpu_ctrl_pkg::power_state_t state_r;
	cpu_ctrl_pkg::power_state_t state_nxt;
	logic                       ack_r;
	logic                       ack_nxt;
	logic                       reset_seen_r;
	logic                       reset_seen_nxt;
	logic                       bus_en_r;
	logic                       bus_en_nxt;
	logic                       inv_r;
	logic                       inv_nxt;
	logic [STRAP_W-1:0]         strap_r;
	logic [STRAP_W-1:0]         strap_nxt;
	logic                       hot_r;
	logic                       hot_nxt;
	logic                       tcc_r;
	logic                       tcc_nxt;
	logic                       in_reset;

	// Board reset or missing power good both hold the core in reset
	assign in_reset = ~link.reset_n | ~link.power_good;

	// Power state sequencing
	always_comb
	begin
		state_nxt      = state_r;
		ack_nxt        = 1'b0;
		reset_seen_nxt = in_reset;
		inv_nxt        = 1'b0;
		strap_nxt      = strap_r;
		case (state_r)
			cpu_ctrl_pkg::ST_RESET:
			begin
				inv_nxt = in_reset;
				if (!in_reset)
				begin
					state_nxt = cpu_ctrl_pkg::ST_RUN;
					strap_nxt = link.strap_bus;
				end
			end
			cpu_ctrl_pkg::ST_RUN:
			begin
				// Sleep request here is simply not looked at
				if (!link.stop_clock_request_n)
				begin
					state_nxt = cpu_ctrl_pkg::ST_STOP_GRANT;
					ack_nxt   = 1'b1;
				end
			end
			cpu_ctrl_pkg::ST_STOP_GRANT:
			begin
				if (!link.sleep_request_n)
					state_nxt = cpu_ctrl_pkg::ST_SLEEP;
				else if (link.stop_clock_request_n)
					state_nxt = cpu_ctrl_pkg::ST_RUN;
			end
			cpu_ctrl_pkg::ST_SLEEP:
			begin
				// Only sleep release and reset are looked at here
				if (link.sleep_request_n)
					state_nxt = cpu_ctrl_pkg::ST_STOP_GRANT;
			end
			default:
				state_nxt = cpu_ctrl_pkg::ST_RESET;
		endcase
		if (in_reset)
		begin
			state_nxt = cpu_ctrl_pkg::ST_RESET;
			ack_nxt   = 1'b0;
		end
		// Release bus output enable at the second edge after reset is seen gone
		bus_en_nxt = ~(in_reset | reset_seen_r);
	end

	// Power state registers
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r      <= cpu_ctrl_pkg::ST_RESET;
			ack_r        <= 1'b0;
			reset_seen_r <= 1'b1;
			bus_en_r     <= 1'b0;
			inv_r        <= 1'b0;
			strap_r      <= STRAP_W'(cpu_ctrl_pkg::STRAP_RST);
		end
		else
		begin
			state_r      <= state_nxt;
			ack_r        <= ack_nxt;
			reset_seen_r <= reset_seen_nxt;
			bus_en_r     <= bus_en_nxt;
			inv_r        <= inv_nxt;
			strap_r      <= strap_nxt;
		end
	end

	// Thermal alert drive and control circuit engagement
	always_comb
	begin
		hot_nxt = temp_max_in & ~in_reset;
		// Circuit follows own sensor or the wired alert level; the wired
		// line also carries our own drive, so release by the board alone does not end it
		tcc_nxt = tcc_enable_in &
			(hot_r | ~link.thermal_alert_n);
	end

	// Thermal registers
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			hot_r <= 1'b0;
			tcc_r <= 1'b0;
		end
		else
		begin
			hot_r <= hot_nxt;
			tcc_r <= tcc_nxt;
		end
	end

	// Clock gating per power state; decoded from the state register
	// only, so a raw pin change can never glitch an enable
	always_comb
	begin
		core_clk_en_out = 1'b0;
		bus_clk_en_out  = 1'b0;
		apic_clk_en_out = 1'b0;
		case (state_r)
			cpu_ctrl_pkg::ST_RUN:
			begin
				core_clk_en_out = 1'b1;
				bus_clk_en_out  = 1'b1;
				apic_clk_en_out = 1'b1;
			end
			cpu_ctrl_pkg::ST_STOP_GRANT:
			begin
				// Core stops; bus and interrupt units keep snooping
				bus_clk_en_out  = 1'b1;
				apic_clk_en_out = 1'b1;
			end
			cpu_ctrl_pkg::ST_SLEEP:
			begin
				// Every unit gated; only the loop keeps running
				core_clk_en_out = 1'b0;
			end
			default:
			begin
				core_clk_en_out = 1'b0;
			end
		endcase
		// Snoops and interrupts only land while the bus unit is clocked
		snoop_accept_out = bus_clk_en_out & snoop_req_in;
		irq_accept_out   = bus_clk_en_out & irq_req_in;
	end

	// Status and pin outputs from registers; pll_on_out is tied high and bus_out_en_out is gated by bus_out_req_in
	assign pll_on_out                  = 1'b1;
	assign executing_out               = core_clk_en_out;
	assign thermal_control_circuit_out = tcc_r;
	assign link.thermal_alert_dev_oe   = hot_r;
	assign link.stop_grant_ack         = ack_r;
	assign cache_invalidate_out        = inv_r;
	assign bus_out_en_out              = bus_en_r & bus_out_req_in;
	assign strap_out                   = strap_r;
	assign power_state_out             = state_r;

endmodule

// ===== hdl/cpu_ctrl_pkg.sv
package cpu_ctrl_pkg;

	// Clock rate and timing figures
	localparam int unsigned CLK_MHZ            = 250;
	localparam int unsigned POR_HOLD_US        = 1000;
	localparam int unsigned RESET_MAX_US       = 10000;
	localparam int unsigned POR_HOLD_CYCLES    = POR_HOLD_US * CLK_MHZ;
	localparam int unsigned RESET_MAX_CYCLES   = RESET_MAX_US * CLK_MHZ;
	localparam int unsigned BUS_RELEASE_CYCLES = 2;

	// Width of the strap word caught at reset release
	localparam int unsigned STRAP_W = 8;

	// Reset values
	localparam logic [7:0] STRAP_RST = 8'h00;

	// Power state of the device
	typedef enum logic [1:0] {
		ST_RESET,
		ST_RUN,
		ST_STOP_GRANT,
		ST_SLEEP
	} power_state_t;

	// Board sequencer states
	typedef enum logic [1:0] {
		SEQ_OFF,
		SEQ_HOLD,
		SEQ_RUN
	} seq_state_t;

endpackage

// ===== hdl/cpu_ctrl_if.sv
`timescale 1ns/100ps
interface cpu_ctrl_if;

	logic                              power_good;
	logic                              reset_n;
	logic                              sleep_request_n;
	logic                              stop_clock_request_n;
	// Open-drain thermal alert: low if either end enables drive
	logic                              thermal_alert_dev_oe;
	logic                              thermal_alert_sys_oe;
	logic                              thermal_alert_n;
	logic [cpu_ctrl_pkg::STRAP_W-1:0]  strap_bus;
	logic                              strap_oe;
	logic                              stop_grant_ack;

	assign thermal_alert_n = ~(thermal_alert_dev_oe | thermal_alert_sys_oe);

	modport device (
		input  power_good,
		input  reset_n,
		input  sleep_request_n,
		input  stop_clock_request_n,
		input  thermal_alert_n,
		output thermal_alert_dev_oe,
		input  strap_bus,
		output stop_grant_ack
	);

	modport system (
		output power_good,
		output reset_n,
		output sleep_request_n,
		output stop_clock_request_n,
		input  thermal_alert_n,
		output thermal_alert_sys_oe,
		output strap_bus,
		output strap_oe,
		input  stop_grant_ack
	);

endinterface

// ===== hdl/cpu_board_sequencer.sv
`timescale 1ns/100ps
module cpu_board_sequencer #(
	parameter int unsigned POR_HOLD_CYCLES  = cpu_ctrl_pkg::POR_HOLD_CYCLES,
	parameter int unsigned RESET_MAX_CYCLES = cpu_ctrl_pkg::RESET_MAX_CYCLES,
	parameter int unsigned STRAP_W          = cpu_ctrl_pkg::STRAP_W
) (
	input  wire logic               mclk_in,
	input  wire logic               rst_in,
	cpu_ctrl_if.system              link,
	input  wire logic               supplies_ok_in,
	input  wire logic               scan_active_in,
	input  wire logic               reset_req_in,
	input  wire logic               stop_clock_in,
	input  wire logic               sleep_in,
	input  wire logic               force_hot_in,
	input  wire logic [STRAP_W-1:0] strap_in,
	output logic                    cpu_hot_out,
	output logic                    ack_seen_out,
	output logic                    reset_out
);

	cpu_ctrl_pkg::seq_state_t st_r;
	cpu_ctrl_pkg::seq_state_t st_nxt;
	logic [31:0]              cnt_r;
	logic [31:0]              cnt_nxt;
	logic                     pg_r;
	logic                     pg_nxt;
	logic                     rst_n_r;
	logic                     rst_n_nxt;
	logic                     hot_r;
	logic                     ack_r;
	logic                     strap_drive_r;
	logic                     strap_drive_nxt;
	logic                     strap_drive;

	// Power good and reset sequencing
	always_comb
	begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		pg_nxt    = pg_r;
		rst_n_nxt = rst_n_r;
		// Remembers that reset was still held one cycle ago
		strap_drive_nxt = ~rst_n_r;
		case (st_r)
			cpu_ctrl_pkg::SEQ_OFF:
			begin
				pg_nxt    = 1'b0;
				rst_n_nxt = 1'b0;
				cnt_nxt   = 32'h0000_0000;
				if (supplies_ok_in)
					st_nxt = cpu_ctrl_pkg::SEQ_HOLD;
			end
			cpu_ctrl_pkg::SEQ_HOLD:
			begin
				pg_nxt  = 1'b1;
				cnt_nxt = cnt_r + 32'h0000_0001;
				// Release after minimum hold, well before the ceiling
				if (cnt_r >= 32'(POR_HOLD_CYCLES))
				begin
					rst_n_nxt = 1'b1;
					st_nxt    = cpu_ctrl_pkg::SEQ_RUN;
				end
				else if (cnt_r >= 32'(RESET_MAX_CYCLES - 1))
				begin
					rst_n_nxt = 1'b1;
					st_nxt    = cpu_ctrl_pkg::SEQ_RUN;
				end
			end
			cpu_ctrl_pkg::SEQ_RUN:
			begin
				if (reset_req_in && !scan_active_in)
				begin
					rst_n_nxt = 1'b0;
					cnt_nxt   = 32'h0000_0000;
					st_nxt    = cpu_ctrl_pkg::SEQ_HOLD;
				end
			end
			default:
				st_nxt = cpu_ctrl_pkg::SEQ_OFF;
		endcase
		// Supply loss drops power good at once unless scan_active_in is set; rise waits for OFF->HOLD
		if (!supplies_ok_in && !scan_active_in)
		begin
			st_nxt    = cpu_ctrl_pkg::SEQ_OFF;
			pg_nxt    = 1'b0;
			rst_n_nxt = 1'b0;
		end
	end

	// Sequencer registers
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_r    <= cpu_ctrl_pkg::SEQ_OFF;
			cnt_r   <= 32'h0000_0000;
			pg_r    <= 1'b0;
			rst_n_r <= 1'b0;
			strap_drive_r <= 1'b1;
			hot_r   <= 1'b0;
			ack_r   <= 1'b0;
		end
		else
		begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			pg_r    <= pg_nxt;
			rst_n_r <= rst_n_nxt;
			strap_drive_r <= strap_drive_nxt;
			hot_r   <= ~link.thermal_alert_n;
			ack_r   <= link.stop_grant_ack;
		end
	end

	assign link.power_good           = pg_r;
	assign link.reset_n              = rst_n_r;
	assign link.stop_clock_request_n = ~stop_clock_in;
	assign link.sleep_request_n      = ~sleep_in;
	assign link.thermal_alert_sys_oe = force_hot_in;
	// Straps held one cycle past reset release: the device samples them
	// at the edge where it first sees reset gone
	assign strap_drive               = ~rst_n_r | strap_drive_r;
	assign link.strap_bus            = strap_drive ? strap_in : '0;
	assign link.strap_oe             = strap_drive;
	assign cpu_hot_out               = hot_r;
	assign ack_seen_out              = ack_r;
	assign reset_out                 = ~rst_n_r;

endmodule

// ===== sim/cpu_ctrl_monitor.sv
`timescale 1ns/100ps
module cpu_ctrl_monitor #(
	parameter int unsigned POR_HOLD_CYCLES  = 20,
	parameter int unsigned RESET_MAX_CYCLES = 200
) (
	input  wire logic mclk_in,
	input  wire logic rst_in,
	input  wire logic power_good,
	input  wire logic reset_n,
	input  wire logic sleep_request_n,
	input  wire logic stop_clock_request_n,
	input  wire logic stop_grant_ack
);

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	logic [31:0] hold_cnt_r;
	logic [31:0] hold_cnt_nxt;

	// Cycles of board reset with power good; clears once reset lifts
	always_comb
	begin
		hold_cnt_nxt = 32'h0000_0000;
		if (power_good && !reset_n)
			hold_cnt_nxt = hold_cnt_r + 32'h0000_0001;
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			hold_cnt_r <= 32'h0000_0000;
		else
			hold_cnt_r <= hold_cnt_nxt;
	end

	// Stop request falling while surely running: no reset, no sleep lately
	sequence s_stop_req;
		reset_n && $past(reset_n) && $past(reset_n, 2)
			&& sleep_request_n && $past(sleep_request_n)
			&& $past(sleep_request_n, 2) && $fell(stop_clock_request_n);
	endsequence
	sequence s_reset_held;
		!reset_n ##1 !reset_n;
	endsequence

	property p_sg_entry;
		s_stop_req |=> stop_grant_ack;
	endproperty
	property p_ack_pulse;
		$rose(stop_grant_ack) |=> !stop_grant_ack;
	endproperty
	property p_ack_cause;
		stop_grant_ack |-> !$past(stop_clock_request_n);
	endproperty
	property p_ack_in_reset;
		s_reset_held |-> !stop_grant_ack;
	endproperty
	property p_pg_reset;
		!power_good |-> !reset_n;
	endproperty
	property p_pg_rise;
		$rose(power_good) |-> !reset_n;
	endproperty
	property p_por_hold;
		$rose(reset_n) |-> hold_cnt_r >= POR_HOLD_CYCLES;
	endproperty
	property p_reset_max;
		power_good |-> hold_cnt_r <= RESET_MAX_CYCLES;
	endproperty

	a_sg_entry: assert property (p_sg_entry)
		else $error("no stop grant ack after stop request");
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("stop grant ack longer than one cycle");
	a_ack_cause: assert property (p_ack_cause)
		else $error("stop grant ack without stop request");
	a_ack_in_reset: assert property (p_ack_in_reset)
		else $error("stop grant ack during reset");
	a_pg_reset: assert property (p_pg_reset)
		else $error("reset released without power good");
	a_pg_rise: assert property (p_pg_rise)
		else $error("power good rose outside reset");
	a_por_hold: assert property (p_por_hold)
		else $error("power-on reset hold too short");
	a_reset_max: assert property (p_reset_max)
		else $error("reset held too long with power good");

endmodule

// ===== sim/tb_cpu_reset_sleep_thermal_ctrl.sv
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 100) begin \
	@(negedge mclk_in); k++; end if (!(c)) miscompares++; end
module tb_cpu_reset_sleep_thermal_ctrl;

	logic       mclk_in, rst_in, temp_max_in, tcc_enable_in, snoop_req_in;
	logic       irq_req_in, bus_out_req_in, supplies_ok_in, scan_active_in;
	logic       reset_req_in, stop_clock_in, sleep_in, force_hot_in;
	logic [7:0] strap_in, strap_out;
	logic       thermal_control_circuit, core_en, bus_en, apic_en, pll_on, executing, cache_inv;
	logic       bus_out_en, snoop_acc, irq_acc, cpu_hot, ack_seen, reset_out;
	logic [1:0] state;
	int         miscompares, comparisons, k;

	cpu_ctrl_if cpu_ctrl_if_inst ();

	cpu_reset_sleep_thermal_ctrl cpu_reset_sleep_thermal_ctrl_inst (
		.mclk_in(mclk_in), .rst_in(rst_in), .link(cpu_ctrl_if_inst),
		.temp_max_in(temp_max_in), .tcc_enable_in(tcc_enable_in),
		.snoop_req_in(snoop_req_in), .irq_req_in(irq_req_in),
		.bus_out_req_in(bus_out_req_in),
		.thermal_control_circuit_out(thermal_control_circuit), .core_clk_en_out(core_en),
		.bus_clk_en_out(bus_en), .apic_clk_en_out(apic_en),
		.pll_on_out(pll_on), .executing_out(executing),
		.cache_invalidate_out(cache_inv), .bus_out_en_out(bus_out_en),
		.snoop_accept_out(snoop_acc), .irq_accept_out(irq_acc),
		.strap_out(strap_out), .power_state_out(state));

	// Short reset counts keep the run brief
	cpu_board_sequencer #(.POR_HOLD_CYCLES(20), .RESET_MAX_CYCLES(200))
	cpu_board_sequencer_inst (
		.mclk_in(mclk_in), .rst_in(rst_in), .link(cpu_ctrl_if_inst),
		.supplies_ok_in(supplies_ok_in), .scan_active_in(scan_active_in),
		.reset_req_in(reset_req_in), .stop_clock_in(stop_clock_in),
		.sleep_in(sleep_in), .force_hot_in(force_hot_in),
		.strap_in(strap_in), .cpu_hot_out(cpu_hot),
		.ack_seen_out(ack_seen), .reset_out(reset_out));

	cpu_ctrl_monitor #(.POR_HOLD_CYCLES(20), .RESET_MAX_CYCLES(200))
	cpu_ctrl_monitor_inst (
		.mclk_in(mclk_in), .rst_in(rst_in),
		.power_good(cpu_ctrl_if_inst.power_good),
		.reset_n(cpu_ctrl_if_inst.reset_n),
		.sleep_request_n(cpu_ctrl_if_inst.sleep_request_n),
		.stop_clock_request_n(cpu_ctrl_if_inst.stop_clock_request_n),
		.stop_grant_ack(cpu_ctrl_if_inst.stop_grant_ack));

	initial
	begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end

	task automatic step(input int n);
		repeat (n) @(negedge mclk_in);
	endtask

	task automatic test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Run is about a hundred cycles; this catches a hang
	initial
	begin
		#20000;
		miscompares++;
		test_done();
	end

	// Inputs change on the falling edge only
	initial
	begin
		{temp_max_in, scan_active_in, reset_req_in, stop_clock_in} = 4'h0;
		{sleep_in, force_hot_in} = 2'b00;
		{tcc_enable_in, snoop_req_in, irq_req_in, bus_out_req_in} = 4'hf;
		supplies_ok_in = 1'b1;
		strap_in = 8'ha5;
		rst_in = 1'b1;
		step(3);
		rst_in = 1'b0;
		step(4);
		`CHK(cache_inv, 1'b1)
		`CHK(bus_out_en, 1'b0)
		`CHK(cpu_ctrl_if_inst.strap_oe, 1'b1)
		`WAITC(reset_out === 1'b0)
		step(3);
		`CHK(state, 2'h1)
		`CHK(strap_out, 8'ha5)
		`CHK({bus_out_en, cache_inv}, 2'b10)
		`CHK(cpu_ctrl_if_inst.strap_oe, 1'b0)
		sleep_in = 1'b1;
		step(2);
		`CHK(state, 2'h1)
		sleep_in = 1'b0;
		stop_clock_in = 1'b1;
		step(1);
		`CHK({state, cpu_ctrl_if_inst.stop_grant_ack}, 3'b101)
		`CHK({core_en, bus_en, apic_en, snoop_acc, irq_acc}, 5'h0f)
		sleep_in = 1'b1;
		step(1);
		`CHK(state, 2'h3)
		`CHK({core_en, bus_en, apic_en, pll_on}, 4'h1)
		`CHK({snoop_acc, irq_acc}, 2'b00)
		stop_clock_in = 1'b0;
		step(2);
		`CHK(state, 2'h3)
		stop_clock_in = 1'b1;
		sleep_in = 1'b0;
		step(1);
		`CHK({state, bus_en}, 3'b101)
		stop_clock_in = 1'b0;
		step(1);
		`CHK({state, executing}, 3'b011)
		temp_max_in = 1'b1;
		step(3);
		`CHK({cpu_ctrl_if_inst.thermal_alert_n, thermal_control_circuit, cpu_hot}, 3'b011)
		temp_max_in = 1'b0;
		force_hot_in = 1'b1;
		step(3);
		`CHK(thermal_control_circuit, 1'b1)
		tcc_enable_in = 1'b0;
		step(2);
		`CHK(thermal_control_circuit, 1'b0)
		tcc_enable_in = 1'b1;
		force_hot_in = 1'b0;
		step(2);
		`CHK(thermal_control_circuit, 1'b0)
		stop_clock_in = 1'b1;
		step(1);
		sleep_in = 1'b1;
		step(1);
		`CHK({state, ack_seen}, 3'b111)
		reset_req_in = 1'b1;
		step(3);
		`CHK({state, bus_out_en}, 3'b000)
		{reset_req_in, stop_clock_in, sleep_in} = 3'b000;
		`WAITC(reset_out === 1'b0)
		step(3);
		`CHK(state, 2'h1)
		scan_active_in = 1'b1;
		supplies_ok_in = 1'b0;
		step(3);
		`CHK({cpu_ctrl_if_inst.power_good, state}, 3'b101)
		scan_active_in = 1'b0;
		step(3);
		`CHK({cpu_ctrl_if_inst.power_good, state}, 3'b000)
		supplies_ok_in = 1'b1;
		`WAITC(reset_out === 1'b0)
		step(3);
		`CHK({state, strap_out}, 10'h1a5)
		test_done();
	end

endmodule
